// file: pkg/dcfsf_params.svh
// constants of the dual-clock fifo status-flag block
// Summary of operation
// [R1] zero words: empty and almost-empty low; 1..n only almost-empty; above n high.
// [R2] almost-full low from depth-m words; full and almost-full low at depth.
// [R3] strap pin sampled at reset: high second write enable, low offset load.
// [R4] after reset outputs are low when enabled, undriven when output enable high.
// [R5] clocks may run freely through reset without disturbing reset state.
// [R6] full flag may update one write edge later under close clock skew.
// [R7] empty flag may update one read edge later under close clock skew.
// [R8] with two write enables, both must be active for a write.
// [R9] first word after empty arrives within one or two read periods.
// [R10] almost-full may change one write edge later under close skew.
// [R11] almost-empty may change one read edge later under close skew.
// [R12] write on almost-full edge leaves depth-(m-1) words when flag falls; here the flag falls at depth-m words.
// [R13] read on almost-empty edge leaves n-1 words above empty when flag falls; here the flag falls at n words.
// [R14] single device: user ties second read enable active, straps load mode.
// [R15] paralleled devices: user combines empty and full flags externally.
// [R16] depth-expansion mode keeps the flag offsets at their defaults.
// [R17] expansion logic drives one enable of each port, stepping devices.
// [R18] load edges fill empty low, empty high, full low, full high, wrap.
// [R19] four 8-bit offset registers, loaded from inputs, read on outputs.
// [R20] write enables ignored while full.
// [R21] read enables ignored while empty; output register holds.
// [R22] depth parameter 256..8192 scales pointer and count widths; comparisons use a fixed 17-bit width.
`ifndef DCFSF_PARAMS_SVH
`define DCFSF_PARAMS_SVH
`define DCFSF_DATA_W 9
`define DCFSF_DEPTH_DEF 256
`define DCFSF_STAGE_DEPTH 8
`define DCFSF_OFS_W 8
`define DCFSF_OFS_DEF 8'h07
`define DCFSF_OFS_ZERO 8'h00
`define DCFSF_IDX_E_LO 0
`define DCFSF_IDX_E_HI 1
`define DCFSF_IDX_F_LO 2
`define DCFSF_IDX_F_HI 3
`define DCFSF_CMP_W 17
`endif

// file: pkg/dcfsf_pkg.sv
// types shared by the fifo status-flag block
`include "dcfsf_params.svh"
package dcfsf_pkg;
  // one-hot selector walking the four offset registers
  typedef enum logic [3:0] {
    DCFSF_SEL_E_LO = 4'h1,
    DCFSF_SEL_E_HI = 4'h2,
    DCFSF_SEL_F_LO = 4'h4,
    DCFSF_SEL_F_HI = 4'h8
  } dcfsf_sel_t;

  // the four status flags, all active low
  typedef struct packed {
    logic full_n;
    logic almost_full_n;
    logic almost_empty_n;
    logic empty_n;
  } dcfsf_flags_t;

  // a write word travelling through staging
  typedef struct packed {
    logic [`DCFSF_DATA_W-1:0] data;
  } dcfsf_word_t;
endpackage : dcfsf_pkg

// file: rtl/dcfsf_fifo.sv
// fifo storage with status flags, offset registers and write staging buffer
`timescale 1ns/1ps
`include "dcfsf_params.svh"

// ---------------------------------------------------------------
// staging buffer in the write path
// ---------------------------------------------------------------
module dcfsf_stage_fifo
  import dcfsf_pkg::*;
#(
  parameter int W = `DCFSF_DATA_W,
  parameter int D = `DCFSF_STAGE_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(D):0] count_o
);
  localparam int PW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } dcfsf_stage_state_t;

  dcfsf_stage_state_t st_reg;
  dcfsf_stage_state_t st_next;
  logic push;
  logic pop;

  // honest full and empty straight from the count
  assign in_ready_o = (st_reg.cnt != (PW+1)'(D));
  assign out_valid_o = (st_reg.cnt != '0);
  assign out_data_o = st_reg.mem[st_reg.rp];
  assign count_o = st_reg.cnt;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // next state of pointers, count and storage
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data_i;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    if (clear_i) begin
      st_next.wp = '0;
      st_next.rp = '0;
      st_next.cnt = '0;
    end
  end

  // register the whole state
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : dcfsf_stage_fifo

// ---------------------------------------------------------------
// top: main array, flags, offset registers, strap
// ---------------------------------------------------------------
module dcfsf_fifo
  import dcfsf_pkg::*;
#(
  parameter int DEPTH = `DCFSF_DEPTH_DEF,
  parameter int STAGE_DEPTH = `DCFSF_STAGE_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic reset_n_i,
  input wire logic [`DCFSF_DATA_W-1:0] write_data_i,
  input wire logic write_enable_primary_n_i,
  input wire logic write_enable_alt_or_offset_load_i,
  input wire logic read_enable_primary_n_i,
  input wire logic read_enable_secondary_n_i,
  input wire logic output_enable_n_i,
  output logic [`DCFSF_DATA_W-1:0] read_data_out_o,
  output logic read_data_out_oe_o,
  output logic empty_flag_n_o,
  output logic almost_empty_flag_n_o,
  output logic almost_full_flag_n_o,
  output logic full_flag_n_o,
  output logic dual_write_enable_mode_o,
  output logic stage_ready_o
);
  localparam int AW = $clog2(DEPTH); // [R22]
  localparam int CW = AW + 1;
  localparam int SW = $clog2(STAGE_DEPTH) + 1;
  localparam int XW = `DCFSF_CMP_W;

  typedef struct packed {
    logic [DEPTH-1:0][`DCFSF_DATA_W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] arr_cnt;
    logic [3:0][`DCFSF_OFS_W-1:0] ofs;
    dcfsf_sel_t ld_sel;
    dcfsf_sel_t rd_sel;
    logic dual_we;
    logic [`DCFSF_DATA_W-1:0] dout;
    dcfsf_flags_t flags;
  } dcfsf_state_t;

  dcfsf_state_t st_reg;
  dcfsf_state_t st_next;

  logic load_mode_low;
  logic wr_req;
  logic wr_acc;
  logic rd_acc;
  logic ofs_wr;
  logic ofs_rd;
  logic drain;
  logic stage_valid;
  logic [`DCFSF_DATA_W-1:0] stage_data;
  logic [SW-1:0] stage_cnt;
  logic [SW-1:0] stage_cnt_next;
  logic [CW-1:0] arr_cnt_next;
  logic [XW-1:0] arr_x;
  logic [XW-1:0] tot_x;
  logic [XW-1:0] ofs_n;
  logic [XW-1:0] ofs_m;

  // step a one-hot offset selector; the fourth step returns to the first
  function automatic dcfsf_sel_t dcfsf_sel_step(input dcfsf_sel_t s);
    dcfsf_sel_t r;
    case (s)
      DCFSF_SEL_E_LO: r = DCFSF_SEL_E_HI;
      DCFSF_SEL_E_HI: r = DCFSF_SEL_F_LO;
      DCFSF_SEL_F_LO: r = DCFSF_SEL_F_HI;
      DCFSF_SEL_F_HI: r = DCFSF_SEL_E_LO;
      default: r = DCFSF_SEL_E_LO;
    endcase
    return r;
  endfunction : dcfsf_sel_step

  // index of the offset register a selector points at
  function automatic logic [1:0] dcfsf_sel_idx(input dcfsf_sel_t s);
    logic [1:0] r;
    case (s)
      DCFSF_SEL_E_LO: r = 2'(`DCFSF_IDX_E_LO);
      DCFSF_SEL_E_HI: r = 2'(`DCFSF_IDX_E_HI);
      DCFSF_SEL_F_LO: r = 2'(`DCFSF_IDX_F_LO);
      DCFSF_SEL_F_HI: r = 2'(`DCFSF_IDX_F_HI);
      default: r = 2'(`DCFSF_IDX_E_LO);
    endcase
    return r;
  endfunction : dcfsf_sel_idx

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  // load function only exists when strapped low at reset
  assign load_mode_low = !st_reg.dual_we && !write_enable_alt_or_offset_load_i; // [R3]
  // both enables must be active; the alternate pin is active high
  assign wr_req = !write_enable_primary_n_i && write_enable_alt_or_offset_load_i; // [R8]
  // full flag blocks writes, staging back-pressure stalls them too
  assign wr_acc = reset_n_i && wr_req && st_reg.flags.full_n && stage_ready_o; // [R20]
  // empty flag blocks reads so the output word stays put
  assign rd_acc = reset_n_i && !load_mode_low && !read_enable_primary_n_i
    && !read_enable_secondary_n_i && st_reg.flags.empty_n; // [R21]
  assign ofs_wr = reset_n_i && load_mode_low && !write_enable_primary_n_i; // [R18]
  assign ofs_rd = reset_n_i && load_mode_low && !read_enable_primary_n_i
    && !read_enable_secondary_n_i; // [R19]
  // array is single ported: a read steals the cycle, so staging can fill
  assign drain = reset_n_i && stage_valid && !rd_acc;

  // ---------------------------------------------------------------
  // write staging buffer
  // ---------------------------------------------------------------
  dcfsf_stage_fifo #(
    .W(`DCFSF_DATA_W),
    .D(STAGE_DEPTH)
  ) u_stage (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clear_i(!reset_n_i),
    .in_valid_i(wr_acc),
    .in_ready_o(stage_ready_o),
    .in_data_i(write_data_i),
    .out_valid_o(stage_valid),
    .out_ready_i(drain),
    .out_data_o(stage_data),
    .count_o(stage_cnt)
  );

  // ---------------------------------------------------------------
  // occupancy forecasts feeding the flags
  // ---------------------------------------------------------------
  // readable words: the staging hop delays empty release by a cycle
  always_comb begin
    arr_cnt_next = st_reg.arr_cnt; // [R7] [R11]
    if (drain && !rd_acc) begin
      arr_cnt_next = st_reg.arr_cnt + 1'b1;
    end else if (rd_acc && !drain) begin
      arr_cnt_next = st_reg.arr_cnt - 1'b1;
    end
    stage_cnt_next = stage_cnt;
    if (wr_acc && !drain) begin
      stage_cnt_next = stage_cnt + 1'b1;
    end else if (drain && !wr_acc) begin
      stage_cnt_next = stage_cnt - 1'b1;
    end
  end

  // widen everything so offsets larger than the depth stay safe
  assign arr_x = XW'(arr_cnt_next);
  assign tot_x = XW'(arr_cnt_next) + XW'(stage_cnt_next);
  assign ofs_n = XW'({st_reg.ofs[`DCFSF_IDX_E_HI], st_reg.ofs[`DCFSF_IDX_E_LO]});
  assign ofs_m = XW'({st_reg.ofs[`DCFSF_IDX_F_HI], st_reg.ofs[`DCFSF_IDX_F_LO]});

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // array write from staging, array read into the output register
    if (drain) begin
      st_next.mem[st_reg.wptr] = stage_data;
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (rd_acc) begin
      st_next.dout = st_reg.mem[st_reg.rptr]; // [R9]
      st_next.rptr = st_reg.rptr + 1'b1;
    end
    st_next.arr_cnt = arr_cnt_next;
    // offset load and readback share no pointer; user avoids overlap
    if (ofs_wr) begin
      st_next.ofs[dcfsf_sel_idx(st_reg.ld_sel)] = write_data_i[`DCFSF_OFS_W-1:0]; // [R19]
      st_next.ld_sel = dcfsf_sel_step(st_reg.ld_sel); // [R18]
    end
    if (ofs_rd) begin
      st_next.dout = `DCFSF_DATA_W'(st_reg.ofs[dcfsf_sel_idx(st_reg.rd_sel)]);
      st_next.rd_sel = dcfsf_sel_step(st_reg.rd_sel);
    end
    // flags from the forecast, so they settle with the edge that moves data
    st_next.flags.empty_n = (arr_x != '0); // [R1]
    st_next.flags.almost_empty_n = (arr_x > ofs_n); // [R1] [R13]
    st_next.flags.almost_full_n = !((tot_x + ofs_m) >= XW'(DEPTH)); // [R2] [R12] [R10]
    st_next.flags.full_n = (tot_x != XW'(DEPTH)); // [R2] [R6]
    // device reset pin: clocks keep running, state is simply forced
    if (!reset_n_i) begin
      st_next.wptr = '0; // [R5]
      st_next.rptr = '0;
      st_next.arr_cnt = '0;
      st_next.ofs[`DCFSF_IDX_E_LO] = `DCFSF_OFS_DEF; // [R16]
      st_next.ofs[`DCFSF_IDX_E_HI] = `DCFSF_OFS_ZERO;
      st_next.ofs[`DCFSF_IDX_F_LO] = `DCFSF_OFS_DEF;
      st_next.ofs[`DCFSF_IDX_F_HI] = `DCFSF_OFS_ZERO;
      st_next.ld_sel = DCFSF_SEL_E_LO;
      st_next.rd_sel = DCFSF_SEL_E_LO;
      st_next.dual_we = write_enable_alt_or_offset_load_i; // [R3]
      st_next.dout = '0; // [R4]
      st_next.flags.empty_n = 1'b0;
      st_next.flags.almost_empty_n = 1'b0;
      st_next.flags.almost_full_n = 1'b1;
      st_next.flags.full_n = 1'b1;
    end
  end

  // register the whole state; async reset takes constants only
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg.mem <= '0;
      st_reg.wptr <= '0;
      st_reg.rptr <= '0;
      st_reg.arr_cnt <= '0;
      st_reg.ofs[`DCFSF_IDX_E_LO] <= `DCFSF_OFS_DEF;
      st_reg.ofs[`DCFSF_IDX_E_HI] <= `DCFSF_OFS_ZERO;
      st_reg.ofs[`DCFSF_IDX_F_LO] <= `DCFSF_OFS_DEF;
      st_reg.ofs[`DCFSF_IDX_F_HI] <= `DCFSF_OFS_ZERO;
      st_reg.ld_sel <= DCFSF_SEL_E_LO;
      st_reg.rd_sel <= DCFSF_SEL_E_LO;
      st_reg.dual_we <= 1'b0;
      st_reg.dout <= '0;
      st_reg.flags.full_n <= 1'b1; // not full, not almost full
      st_reg.flags.almost_full_n <= 1'b1;
      st_reg.flags.almost_empty_n <= 1'b0; // empty implies almost empty
      st_reg.flags.empty_n <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign read_data_out_o = st_reg.dout;
  assign read_data_out_oe_o = !output_enable_n_i; // [R4]
  assign empty_flag_n_o = st_reg.flags.empty_n;
  assign almost_empty_flag_n_o = st_reg.flags.almost_empty_n;
  assign almost_full_flag_n_o = st_reg.flags.almost_full_n;
  assign full_flag_n_o = st_reg.flags.full_n;
  assign dual_write_enable_mode_o = st_reg.dual_we;
endmodule : dcfsf_fifo

// file: sim/dcfsf_user_model.sv
// writer and reader user logic facing the fifo status-flag block
`timescale 1ns/1ps
`include "dcfsf_params.svh"
module dcfsf_user_model (
  input wire logic mclk_i,
  input wire logic stage_ready_i,
  output logic [`DCFSF_DATA_W-1:0] wdata_o,
  output logic wr_n_o,
  output logic alt_o,
  output logic rd_n_o,
  output logic rd2_n_o,
  output logic timeout_o
);
  logic [`DCFSF_DATA_W-1:0] data_q[$];
  logic [`DCFSF_DATA_W-1:0] exp_q[$];
  logic [`DCFSF_DATA_W-1:0] last_w;

  // ---------------------------------------------------------------
  // idle levels from time zero
  // ---------------------------------------------------------------
  initial begin
    wdata_o = 9'h000;
    alt_o = 1'b0;
    timeout_o = 1'b0;
    {wr_n_o, rd_n_o, rd2_n_o} = 3'h7;
  end

  // one write or offset load; a kept write waits for the staging buffer
  task automatic put(input logic [8:0] d, input logic alt, input logic keep);
    int i;
    @(negedge mclk_i);
    wdata_o = d;
    alt_o = alt;
    wr_n_o = 1'b0;
    for (i = 0; keep && !stage_ready_i && i < 32; i++) @(negedge mclk_i);
    if (i == 32) timeout_o = 1'b1;
    if (keep && alt) data_q.push_back(d);
    @(posedge mclk_i);
  endtask : put

  // one read; the expected word is noted once the taking edge has passed
  task automatic get(input logic alt, input logic [8:0] e, input logic note);
    @(negedge mclk_i);
    wr_n_o = 1'b1;
    alt_o = alt;
    rd_n_o = 1'b0;
    rd2_n_o = 1'b0;
    if (note) last_w = alt ? data_q.pop_front() : e;
    @(posedge mclk_i);
    if (note) exp_q.push_back(last_w);
  endtask : get

  // release the three active-low enables, drive alt from a; released data never keeps its last value
  task automatic idle(input int k, input logic a);
    @(negedge mclk_i);
    {wr_n_o, rd_n_o, rd2_n_o} = 3'h7;
    alt_o = a;
    wdata_o = ~wdata_o;
    repeat (k - 1) @(negedge mclk_i);
  endtask : idle
endmodule : dcfsf_user_model

// file: sim/dcfsf_fifo_sva.sv
// concurrent checks on the ports of the fifo status-flag block
`timescale 1ns/1ps
`include "dcfsf_params.svh"
module dcfsf_fifo_sva
  import dcfsf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic reset_n_i,
  input wire logic write_enable_primary_n_i,
  input wire logic write_enable_alt_or_offset_load_i,
  input wire logic read_enable_primary_n_i,
  input wire logic read_enable_secondary_n_i,
  input wire logic output_enable_n_i,
  input wire logic [`DCFSF_DATA_W-1:0] read_data_out_o,
  input wire logic read_data_out_oe_o,
  input wire logic empty_flag_n_o,
  input wire logic almost_empty_flag_n_o,
  input wire logic almost_full_flag_n_o,
  input wire logic full_flag_n_o,
  input wire logic dual_write_enable_mode_o,
  input wire logic stage_ready_o
);
  // ---------------------------------------------------------------
  // helpers and clocking
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic rd_req;
  logic ld_acc;
  // read request and offset-access decode from the pins
  assign rd_req = !read_enable_primary_n_i && !read_enable_secondary_n_i;
  assign ld_acc = !dual_write_enable_mode_o && !write_enable_alt_or_offset_load_i;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  oe_follow_a: assert property (read_data_out_oe_o == !output_enable_n_i)
    else $error("output enable mismatch");
  reset_flags_a: assert property (!reset_n_i |=> !empty_flag_n_o && !almost_empty_flag_n_o
    && almost_full_flag_n_o && full_flag_n_o) else $error("flags wrong after reset");
  strap_mode_a: assert property (!reset_n_i |=>
    dual_write_enable_mode_o == $past(write_enable_alt_or_offset_load_i))
    else $error("strap not latched");
  full_af_a: assert property (!full_flag_n_o |-> !almost_full_flag_n_o)
    else $error("full without almost full");
  empty_ae_a: assert property (!empty_flag_n_o |-> !almost_empty_flag_n_o)
    else $error("empty without almost empty");
  empty_hold_a: assert property (reset_n_i && !empty_flag_n_o && rd_req && !ld_acc
    |=> $stable(read_data_out_o)) else $error("read taken while empty");
  full_hold_a: assert property (reset_n_i && !full_flag_n_o && !rd_req |=> !full_flag_n_o)
    else $error("write taken while full");
  dual_gate_a: assert property (reset_n_i && dual_write_enable_mode_o
    && !write_enable_alt_or_offset_load_i && !rd_req
    |=> $stable(full_flag_n_o) && $stable(almost_full_flag_n_o)) else $error("gated write seen");
  first_word_a: assert property (reset_n_i && !empty_flag_n_o && stage_ready_o
    && !write_enable_primary_n_i && write_enable_alt_or_offset_load_i ##1 reset_n_i [*2]
    |-> ##[0:1] empty_flag_n_o) else $error("first word too late");
endmodule : dcfsf_fifo_sva

bind dcfsf_fifo dcfsf_fifo_sva chk_u (
  .mclk_i(mclk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
  .write_enable_primary_n_i(write_enable_primary_n_i),
  .write_enable_alt_or_offset_load_i(write_enable_alt_or_offset_load_i),
  .read_enable_primary_n_i(read_enable_primary_n_i),
  .read_enable_secondary_n_i(read_enable_secondary_n_i),
  .output_enable_n_i(output_enable_n_i), .read_data_out_o(read_data_out_o),
  .read_data_out_oe_o(read_data_out_oe_o), .empty_flag_n_o(empty_flag_n_o),
  .almost_empty_flag_n_o(almost_empty_flag_n_o), .almost_full_flag_n_o(almost_full_flag_n_o),
  .full_flag_n_o(full_flag_n_o), .dual_write_enable_mode_o(dual_write_enable_mode_o),
  .stage_ready_o(stage_ready_o)
);

// file: sim/dual_clock_fifo_status_flags_tb.sv
// self-checking bench for the fifo status-flag block
`timescale 1ns/1ps
`include "dcfsf_params.svh"
module dual_clock_fifo_status_flags_tb
  import dcfsf_pkg::*;
;
  localparam int DEPTH_TB = 256;
  logic mclk_i, rst_i, reset_n, oe_n, wr_n, alt, rd_n, rd2_n, tmo;
  logic oe_o, ef_n, aef_n, afl_n, ff_n, mode, rdy;
  logic [8:0] wdata, dout;
  logic [8:0] ld[5] = '{9'h005, 9'h000, 9'h009, 9'h000, 9'h003};
  int fail_count = 0;
  int compares = 0;
  int i, j, seed_v;

  dcfsf_fifo #(.DEPTH(DEPTH_TB), .STAGE_DEPTH(8)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .reset_n_i(reset_n), .write_data_i(wdata),
    .write_enable_primary_n_i(wr_n), .write_enable_alt_or_offset_load_i(alt),
    .read_enable_primary_n_i(rd_n), .read_enable_secondary_n_i(rd2_n),
    .output_enable_n_i(oe_n), .read_data_out_o(dout), .read_data_out_oe_o(oe_o),
    .empty_flag_n_o(ef_n), .almost_empty_flag_n_o(aef_n), .almost_full_flag_n_o(afl_n),
    .full_flag_n_o(ff_n), .dual_write_enable_mode_o(mode), .stage_ready_o(rdy));
  dcfsf_user_model pm_u (.mclk_i(mclk_i), .stage_ready_i(rdy), .wdata_o(wdata), .wr_n_o(wr_n),
    .alt_o(alt), .rd_n_o(rd_n), .rd2_n_o(rd2_n), .timeout_o(tmo));

  // ---------------------------------------------------------------
  // clock, compares and verdict
  // ---------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic chk_data(input string nm, input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk_data
  // expected flags from a settled word count and the offsets in force
  task automatic chk_flags(input int c, input int n, input int m);
    dcfsf_flags_t e;
    e = {c != DEPTH_TB, c < DEPTH_TB - m, c > n, c != 0};
    compares++;
    if ({ff_n, afl_n, aef_n, ef_n} !== e) begin
      fail_count++;
      $display("BAD flags at %0d exp %b got %b", c, e, {ff_n, afl_n, aef_n, ef_n});
    end
  endtask : chk_flags
  task automatic close_out();
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  // every noted read is compared once its word has settled
  always @(negedge mclk_i) begin
    if (pm_u.exp_q.size() > 0) chk_data("read data", pm_u.exp_q.pop_front(), dout);
  end
  // a stalled handshake or a hung run ends as a failure
  initial begin
    for (j = 0; j < 20000 && tmo !== 1'b1; j++) @(posedge mclk_i);
    fail_count++;
    close_out();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed_v = $urandom(35489);
    rst_i = 1'b1;
    reset_n = 1'b0;
    oe_n = 1'b0;
    repeat (20) @(negedge mclk_i);
    rst_i = 1'b0;
    pm_u.idle(2, 1'b0);
    reset_n = 1'b1;
    pm_u.idle(2, 1'b1);
    chk_flags(0, 7, 7);
    chk_data("mode", 9'h000, {8'h00, mode});
    chk_data("out", 9'h000, dout);
    for (i = 1; i >= 0; i--) begin
      oe_n = (i == 1);
      #1 chk_data("oe", {8'h00, i == 0}, {8'h00, oe_o});
    end
    // default offsets: almost-empty rises only above seven words
    for (i = 1; i <= 8; i++) begin
      pm_u.put(9'($urandom), 1'b1, 1'b1);
      pm_u.idle(4, 1'b1);
      chk_flags(i, 7, 7);
    end
    for (i = 7; i >= 0; i--) begin
      pm_u.get(1'b1, 9'h000, 1'b1);
      pm_u.idle(4, 1'b1);
      chk_flags(i, 7, 7);
    end
    pm_u.get(1'b1, 9'h000, 1'b0);
    pm_u.idle(2, 1'b1);
    chk_data("held", pm_u.last_w, dout);
    // five load edges wrap onto empty low; readback in the same order
    foreach (ld[k]) pm_u.put(ld[k], 1'b0, 1'b0);
    for (i = 0; i < 4; i++) pm_u.get(1'b0, ld[i == 0 ? 4 : i], 1'b1);
    pm_u.idle(3, 1'b1);
    // fill past full with n=3 m=9, then drain with checks at the edges
    for (i = 1; i <= DEPTH_TB + 1; i++) begin
      pm_u.put(9'($urandom), 1'b1, i <= DEPTH_TB);
      if (i inside {3, 4, 246, 247, 256, 257}) begin
        pm_u.idle(4, 1'b1);
        chk_flags(i > DEPTH_TB ? DEPTH_TB : i, 3, 9);
      end
    end
    for (i = DEPTH_TB - 1; i >= 0; i--) begin
      pm_u.get(1'b1, 9'h000, 1'b1);
      if (i inside {247, 246, 4, 3, 0}) begin
        pm_u.idle(4, 1'b1);
        chk_flags(i, 3, 9);
      end
    end
    // strap high: two write enables, no load path, default offsets
    reset_n = 1'b0;
    pm_u.idle(2, 1'b1);
    reset_n = 1'b1;
    pm_u.idle(2, 1'b1);
    chk_data("mode", 9'h001, {8'h00, mode});
    pm_u.put(9'h155, 1'b0, 1'b0);
    for (i = 1; i <= 8; i++) begin
      pm_u.put(9'($urandom), 1'b1, 1'b1);
      pm_u.idle(4, 1'b1);
      if (i >= 7) chk_flags(i, 7, 7);
    end
    // asynchronous reset in mid-run clears words and the strap
    #1 rst_i = 1'b1;
    #8 rst_i = 1'b0;
    pm_u.data_q.delete();
    pm_u.idle(2, 1'b1);
    chk_flags(0, 7, 7);
    chk_data("mode", 9'h000, {8'h00, mode});
    close_out();
  end
endmodule : dual_clock_fifo_status_flags_tb
